// File: hdl/ftc_tx_config.sv
// Transmit configuration word with serial command decode and frequency path
// Functional notes
// - Stored offset error added to PLL word
// - Fine mode doubles measurement time
// - Prefix 1001100b writes transmit configuration
// - Word resets to 0x9800
// - Bit 8 selects FSK polarity
// - Polarity clear: level one is higher
// - Bits 7-4 set deviation, 15 kHz steps
// - Output deviation is (code+1) times 15 kHz
// - Bits 2-0 select output attenuation
`timescale 1ns/10ps
`default_nettype none
module ftc_tx_config
	import ftc_pkg::*;
#(
	parameter int unsigned MEAS = MEAS_CYCLES,
	parameter int unsigned W = OFS_W
)
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_spi_sck,
	input wire logic i_spi_sdi,
	input wire logic i_spi_csn,
	input wire logic i_fsk_data,
	input wire logic i_offset_store_enable,
	input wire logic i_manual_offset_sample_strobe,
	input wire logic i_fine_accuracy_select,
	input wire logic signed [W-1:0] i_offset_error,
	input wire logic [W-1:0] i_center_word,
	output logic [15:0] o_transmit_configuration,
	output logic o_fsk_polarity_select,
	output logic [3:0] o_fsk_deviation_code,
	output logic [2:0] o_output_attenuation_code,
	output logic o_freq_high,
	output logic [9:0] o_deviation_khz,
	output logic [W-1:0] o_pll_word,
	output logic o_meas_busy
);
	// Pin synchronisers: stage one feeds only stage two
	logic [2:0] sck_ff; // Two sync stages plus edge history
	logic [1:0] csn_ff; // Chip select sync
	logic [1:0] sdi_ff; // Data in sync
	logic [1:0] dat_ff; // FSK data level sync
	logic [1:0] stb_ff; // Sample strobe sync
	logic csn_q_ff; // Chip select history for edge detect
	logic stb_q_ff; // Strobe history for edge detect

	// Sync stages; idle-level reset values keep the edge detectors from firing after reset
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			sck_ff <= '0;
			csn_ff <= 2'h3;
			sdi_ff <= '0;
			dat_ff <= '0;
			stb_ff <= '0;
			csn_q_ff <= 1'b1;
			stb_q_ff <= 1'b0;
		end
		else
		begin
			sck_ff <= {sck_ff[1], sck_ff[0], i_spi_sck};
			csn_ff <= {csn_ff[0], i_spi_csn};
			sdi_ff <= {sdi_ff[0], i_spi_sdi};
			dat_ff <= {dat_ff[0], i_fsk_data};
			stb_ff <= {stb_ff[0], i_manual_offset_sample_strobe};
			csn_q_ff <= csn_ff[1];
			stb_q_ff <= stb_ff[1];
		end
	end

	logic sck_rise; // Sample point of the serial clock
	logic csn_rise; // End of a command frame
	logic stb_rise; // Host asks for a sample
	assign sck_rise = sck_ff[1] && !sck_ff[2];
	assign csn_rise = csn_ff[1] && !csn_q_ff;
	// Only a fresh rise starts a sample, so the host must drop the strobe first
	assign stb_rise = stb_ff[1] && !stb_q_ff;

	// Command shifter and configuration word
	logic [15:0] shift_ff; // Incoming command, MSB first
	logic [15:0] nxt_shift;
	logic [4:0] nbits_ff; // Bits seen, saturates past a full frame
	logic [4:0] nxt_nbits;
	logic [15:0] cfg_ff; // Transmit configuration word
	logic [15:0] nxt_cfg;

	// Shift on clock rises while selected; commit on deselect
	always_comb
	begin
		nxt_shift = shift_ff;
		nxt_nbits = nbits_ff;
		nxt_cfg = cfg_ff;
		if (csn_ff[1])
		begin
			// Deselected: frame over, start counting afresh
			nxt_nbits = '0;
			// Long or short frames are dropped rather than guessed at
			if (csn_rise && nbits_ff == FRAME_BITS_W
				&& shift_ff[PREFIX_MSB:PREFIX_LSB] == TXCFG_PREFIX)
			begin
				nxt_cfg = shift_ff;
				nxt_cfg[PREFIX_MSB:PREFIX_LSB] = TXCFG_PREFIX;
				nxt_cfg[RSVD_BIT] = 1'b0;
			end
		end
		else if (sck_rise)
		begin
			nxt_shift = {shift_ff[14:0], sdi_ff[1]};
			if (nbits_ff != FRAME_BITS_W + 5'h01)
			begin
				nxt_nbits = nbits_ff + 5'h01;
			end
		end
	end

	// Registers only
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			shift_ff <= '0;
			nbits_ff <= '0;
			cfg_ff <= TXCFG_RESET;
		end
		else
		begin
			shift_ff <= nxt_shift;
			nbits_ff <= nxt_nbits;
			cfg_ff <= nxt_cfg;
		end
	end

	// Offset measurement and store
	logic meas_busy; // Sample running
	logic signed [W-1:0] ofs_store; // Last stored offset error
	ftc_offset_meas #(
		.MEAS(MEAS),
		.W(W)
	) u_meas (
		.i_core_clk(i_core_clk),
		.i_resetn(i_resetn),
		.i_start(stb_rise),
		.i_fine(i_fine_accuracy_select),
		.i_store_en(i_offset_store_enable),
		.i_offset_error(i_offset_error),
		.o_busy(meas_busy),
		.o_done(),
		.o_offset(ofs_store)
	);

	// Frequency path outputs
	logic high_ff; // Higher channel frequency in use
	logic nxt_high;
	logic [9:0] dev_ff; // Deviation magnitude in kHz
	logic [9:0] nxt_dev;
	logic [W-1:0] pll_ff; // PLL control word
	logic [W-1:0] nxt_pll;
	logic busy_ff; // Registered copy of measurement busy
	logic nxt_busy;

	// Polarity and deviation from the configuration, PLL word from centre word and stored offset
	always_comb
	begin
		// Clear polarity sends level one high, set reverses it
		nxt_high = cfg_ff[POL_BIT] ^ dat_ff[1];
		// Deviation is (code + 1) steps of 15 kHz
		nxt_dev = ({6'h00, cfg_ff[DEV_MSB:DEV_LSB]} + 10'h001) * DEV_STEP_KHZ;
		// Stored offset joins the carrier word only while enabled
		nxt_pll = i_offset_store_enable ? i_center_word + ofs_store : i_center_word;
		nxt_busy = meas_busy;
	end

	// Registers only
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			high_ff <= 1'b0;
			dev_ff <= '0;
			pll_ff <= '0;
			busy_ff <= 1'b0;
		end
		else
		begin
			high_ff <= nxt_high;
			dev_ff <= nxt_dev;
			pll_ff <= nxt_pll;
			busy_ff <= nxt_busy;
		end
	end

	// Output drive, all from flip-flops
	assign o_transmit_configuration = cfg_ff;
	assign o_fsk_polarity_select = cfg_ff[POL_BIT];
	assign o_fsk_deviation_code = cfg_ff[DEV_MSB:DEV_LSB];
	// Attenuation code goes straight to the PA, 000 is full power
	assign o_output_attenuation_code = cfg_ff[ATT_MSB:ATT_LSB];
	assign o_freq_high = high_ff;
	assign o_deviation_khz = dev_ff;
	assign o_pll_word = pll_ff;
	assign o_meas_busy = busy_ff;

	cfg_write_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		cfg_ff != $past(cfg_ff) |-> $past(csn_rise) && $past(shift_ff[15:9]) == TXCFG_PREFIX)
		else $error("config changed without a matching command");
	cfg_load_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		csn_rise && nbits_ff == FRAME_BITS_W && shift_ff[15:9] == TXCFG_PREFIX
		|=> cfg_ff[8:4] == $past(shift_ff[8:4]) && cfg_ff[2:0] == $past(shift_ff[2:0]))
		else $error("matching command not stored");
	cfg_reset_a: assert property (@(posedge i_core_clk)
		$past(!i_resetn) |-> cfg_ff == TXCFG_RESET)
		else $error("config not at power-on value");
	rsvd_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!cfg_ff[RSVD_BIT])
		else $error("reserved bit stored");
	pol_map_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		$past(i_resetn) |-> high_ff == ($past(cfg_ff[8]) ^ $past(dat_ff[1])))
		else $error("polarity mapping wrong");
	dev_khz_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		$past(i_resetn) |-> dev_ff == (10'($past(cfg_ff[7:4])) + 10'h001) * 10'h00f)
		else $error("deviation magnitude wrong");
	pll_sum_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		$past(i_resetn) |-> pll_ff == ($past(i_offset_store_enable) ? $past(i_center_word) + $past(ofs_store)
		: $past(i_center_word)))
		else $error("PLL word missing offset");
	strobe_edge_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		$rose(meas_busy) |-> $past(stb_ff[1]) && !$past(stb_q_ff))
		else $error("sample started without a fresh strobe");
endmodule
`default_nettype wire

// File: hdl/ftc_pkg.sv
// Constants shared by the transmit configuration block and its offset measurement unit
package ftc_pkg;
	// Serial command frame
	localparam int unsigned FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_W = 5'h10;
	localparam int unsigned PREFIX_MSB = 15;
	localparam int unsigned PREFIX_LSB = 9;
	localparam logic [6:0] TXCFG_PREFIX = 7'h4c;
	// Transmit configuration word layout and power-on value
	localparam logic [15:0] TXCFG_RESET = 16'h9800;
	localparam int unsigned POL_BIT = 8;
	localparam int unsigned DEV_MSB = 7;
	localparam int unsigned DEV_LSB = 4;
	localparam int unsigned RSVD_BIT = 3;
	localparam int unsigned ATT_MSB = 2;
	localparam int unsigned ATT_LSB = 0;
	// Deviation step in kHz per code step
	localparam logic [9:0] DEV_STEP_KHZ = 10'h00f;
	// Regular offset measurement time in core cycles; fine mode doubles it
	localparam int unsigned MEAS_CYCLES = 16;
	localparam int unsigned FINE_FACTOR = 2;
	// Offset word width
	localparam int unsigned OFS_W = 16;
endpackage

// File: hdl/ftc_offset_meas.sv
// Offset measurement unit: timed sample, optional store of the measured error
`timescale 1ns/10ps
`default_nettype none
module ftc_offset_meas
	import ftc_pkg::*;
#(
	parameter int unsigned MEAS = MEAS_CYCLES,
	parameter int unsigned W = OFS_W
)
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic i_fine,
	input wire logic i_store_en,
	input wire logic signed [W-1:0] i_offset_error,
	output logic o_busy,
	output logic o_done,
	output logic signed [W-1:0] o_offset
);
	localparam int unsigned CW = $clog2(MEAS * FINE_FACTOR + 1);
	localparam logic [CW-1:0] LEN_REG = CW'(MEAS);
	localparam logic [CW-1:0] LEN_FINE = CW'(MEAS * FINE_FACTOR);

	logic [CW-1:0] cnt_ff; // Cycles left in the sample
	logic [CW-1:0] nxt_cnt;
	logic busy_ff; // Sample in progress
	logic nxt_busy;
	logic done_ff; // One-cycle end of sample
	logic nxt_done;
	logic signed [W-1:0] ofs_ff; // Offset store
	logic signed [W-1:0] nxt_ofs;

	// Sample timer; a start while busy is ignored, the host must wait and re-arm
	always_comb
	begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_ofs = ofs_ff;
		if (!busy_ff && i_start)
		begin
			// Fine mode trades double time for less uncertainty
			nxt_cnt = i_fine ? LEN_FINE : LEN_REG;
			nxt_busy = 1'b1;
		end
		else if (busy_ff)
		begin
			if (cnt_ff == CW'(1))
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				// Keep the error only when storing is allowed
				if (i_store_en)
				begin
					nxt_ofs = i_offset_error;
				end
			end
			nxt_cnt = cnt_ff - CW'(1);
		end
	end

	// Registers only
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			ofs_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			ofs_ff <= nxt_ofs;
		end
	end

	assign o_busy = busy_ff;
	assign o_done = done_ff;
	assign o_offset = ofs_ff;

	// Helper: length of the running sample
	logic [CW:0] run_ff;
	logic fine_ff;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			run_ff <= '0;
			fine_ff <= 1'b0;
		end
		else
		begin
			run_ff <= busy_ff ? run_ff + (CW+1)'(1) : '0;
			if (!busy_ff && i_start)
			begin
				fine_ff <= i_fine;
			end
		end
	end

	meas_len_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		$fell(busy_ff) |-> ($past(run_ff) + (CW+1)'(1)) == (fine_ff ? (CW+1)'(LEN_FINE) : (CW+1)'(LEN_REG)))
		else $error("sample length does not match mode");
	store_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		done_ff && !$past(i_store_en) |-> $stable(ofs_ff))
		else $error("offset store changed while disabled");
	store_take_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		done_ff && $past(i_store_en) |-> ofs_ff == $past(i_offset_error))
		else $error("offset store missed the error");
endmodule
`default_nettype wire

// File: dv/ftc_host_model.sv
// Host side model: serial command frames and offset sample strobe
`timescale 1ns/10ps
`default_nettype none
module ftc_host_model
(
	input wire logic i_core_clk,
	output logic o_spi_sck,
	output logic o_spi_sdi,
	output logic o_spi_csn,
	output logic o_strobe
);
	// Idle: deselected, clock parked low
	initial
	begin
		o_spi_sck = 1'b0;
		o_spi_sdi = 1'b0;
		o_spi_csn = 1'b1;
		o_strobe = 1'b0;
	end
	// Phases of 3 edges, longer than the synchronisers need
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// Top nbits of word, MSB first; a short count tests refusal
	task automatic send_frame(input logic [15:0] word, input int nbits);
		@(posedge i_core_clk);
		o_spi_csn <= 1'b0;
		wait_cyc(3);
		for (int i = 15; i > 15 - nbits; i--)
		begin
			o_spi_sdi <= word[i];
			wait_cyc(3);
			o_spi_sck <= 1'b1;
			wait_cyc(3);
			o_spi_sck <= 1'b0;
		end
		wait_cyc(3);
		o_spi_csn <= 1'b1;
		// Released line must not keep showing the last bit
		o_spi_sdi <= ~o_spi_sdi;
		wait_cyc(6);
	endtask
	// Strobe level; it is dropped before any new sample
	task automatic strobe_set(input logic v);
		@(posedge i_core_clk);
		o_strobe <= v;
	endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the transmit configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int MEAS = 4; // Short sample for simulation
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic data = 1'b0;
	logic store_en = 1'b0;
	logic fine = 1'b0;
	logic signed [15:0] ofs_err = 16'h0010;
	logic [15:0] center = 16'h1000;
	wire logic sck, sdi, csn, strobe;
	logic [15:0] cfg, pll;
	logic pol, fhi, busy;
	logic [3:0] dev;
	logic [2:0] att;
	logic [9:0] dkhz;
	logic [15:0] w;
	int n_mismatch = 0;
	int cmp_count = 0;

	// Core clock, 100 MHz
	always #5 clk = ~clk;

	ftc_host_model host (.i_core_clk(clk), .o_spi_sck(sck), .o_spi_sdi(sdi), .o_spi_csn(csn), .o_strobe(strobe));

	ftc_tx_config #(.MEAS(MEAS)) uut (.i_core_clk(clk), .i_resetn(resetn), .i_spi_sck(sck),
		.i_spi_sdi(sdi), .i_spi_csn(csn), .i_fsk_data(data), .i_offset_store_enable(store_en),
		.i_manual_offset_sample_strobe(strobe), .i_fine_accuracy_select(fine),
		.i_offset_error(ofs_err), .i_center_word(center), .o_transmit_configuration(cfg),
		.o_fsk_polarity_select(pol), .o_fsk_deviation_code(dev), .o_output_attenuation_code(att),
		.o_freq_high(fhi), .o_deviation_khz(dkhz), .o_pll_word(pll), .o_meas_busy(busy));

	// Compare and count
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One sample; strobe stays high all along, so a restart would lengthen busy
	task automatic run_sample(input logic f, input logic s, input int len, input logic [15:0] exp_pll);
		int n;
		n = 0;
		@(posedge clk);
		fine <= f;
		store_en <= s;
		host.strobe_set(1'b1);
		repeat (60)
		begin
			@(posedge clk);
			#1;
			if (busy === 1'b1)
				n++;
		end
		chk("busy_len", n[15:0], len[15:0]);
		chk("pll_word", pll, exp_pll);
		host.strobe_set(1'b0);
		repeat (4) @(posedge clk);
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk("config", cfg, 16'h9800);
		chk("polarity", pol, 16'h0000);
		chk("dev_code", dev, 16'h0000);
		chk("atten", att, 16'h0000);
		$display("Test reset done");
		// Every deviation code; reserved bit always written as 1
		for (int i = 0; i < 16; i++)
		begin
			w = {7'h4c, i[0], i[3:0], 1'b1, i[2:0]};
			host.send_frame(w, 16);
			@(posedge clk);
			data <= i[1];
			repeat (5) @(posedge clk);
			#1;
			chk("config", cfg, w & 16'hfff7);
			chk("polarity", pol, i[0]);
			chk("dev_code", dev, i[3:0]);
			chk("dev_khz", dkhz, 16'((i + 1) * 15));
			chk("atten", att, i[2:0]);
			chk("freq_high", fhi, i[0] ^ i[1]);
		end
		$display("Test fields done");
		// Wrong prefix, then a short frame: both ignored
		host.send_frame(16'h9b55, 16);
		host.send_frame(16'h9955, 15);
		#1;
		chk("config", cfg, 16'h99f7);
		$display("Test refusal done");
		// Reset again in mid-run: the written word must fall back to its power-on value
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk("config", cfg, 16'h9800);
		chk("polarity", pol, 16'h0000);
		$display("Test mid-run reset done");
		run_sample(1'b0, 1'b1, MEAS, 16'h1010);
		ofs_err <= 16'h0020;
		run_sample(1'b1, 1'b1, 2 * MEAS, 16'h1020);
		ofs_err <= 16'h0030;
		run_sample(1'b0, 1'b0, MEAS, 16'h1000);
		// Store was off at the end of that sample, so the earlier offset must remain
		store_en <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("pll_kept", pll, 16'h1020);
		$display("Test offset done");
		report_and_stop();
	end

	// Watchdog, well beyond the expected 2270 or so cycles
	initial
	begin
		#200000;
		n_mismatch++;
		$display("Watchdog expired");
		report_and_stop();
	end
endmodule
`default_nettype wire
